// ### core/fwbd_decode.v
/*
 * fuse word decoder: keeps a readable image of the low general fuse
 * word, decodes brown-out detector configuration from it and forwards
 * the flash protection fuses; software reaches it over ahb-lite.
 * assumes the fuse array presents a stable word on fuse_word_in at
 * reset release, and the reset controller flags a brown-out reset on
 * bod_reset_cause while reset is high.
 */
`include "fwbd_defs.vh"

module fwbd_decode (
  input wire ref_clk,
  input wire reset,
  input wire bod_reset_cause,
  input wire [31:0] fuse_word_in,
  input wire chip_erase_req,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg bod_enable,
  output reg bod_reset_enable,
  output reg bod_hysteresis,
  output reg [5:0] bod_level,
  output reg bod_level_below_por,
  output reg [15:0] flash_region_lock,
  output reg flash_user_page_protect,
  output reg [1:0] flash_readout_protect_pair,
  output reg [2:0] flash_boot_area_protect,
  output reg flash_boot_protect_off,
  output reg flash_fetch_unlocked,
  output reg [6:0] flash_fuse_bits
);

  // ****************************************************************
  // load sequencer states
  // ****************************************************************
  localparam [2:0] ST_LOAD = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_ERASE = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] general_fuse_low_word;
  reg [31:0] next_fuse;
  reg [31:0] bodctl;
  reg kept_on_bod;
  reg loaded;
  reg erased;
  wire wr_stb;
  wire [7:0] wr_ofs;
  wire [31:0] wr_data;
  wire [31:0] status_image;
  wire [1:0] bod_mode;
  wire [15:0] lock_active;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // returns {detector on, detector reset on} for an enable code
  function [1:0] bod_mode_of;
    input [1:0] code;
    begin
      case (code)
        `FWBD_EN_RST: begin
          bod_mode_of = 2'h3;
        end
        `FWBD_EN_NORST: begin
          bod_mode_of = 2'h2;
        end
        default: begin
          bod_mode_of = 2'h0;
        end
      endcase
    end
  endfunction

  // keeps only the detector fields of a word
  function [31:0] bod_fields;
    input [31:0] word;
    begin
      bod_fields = word & `FWBD_BODCTL_MASK;
    end
  endfunction

  assign status_image = {29'h0000_0000, kept_on_bod, erased, loaded};

  // ****************************************************************
  // bus slave
  // ****************************************************************
  fwbd_ahb_slave u_slave (
    .ref_clk(ref_clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .fuse_image(general_fuse_low_word),
    .bodctl_image(bodctl),
    .status_image(status_image),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_stb(wr_stb),
    .wr_ofs(wr_ofs),
    .wr_data(wr_data)
  );

  // ****************************************************************
  // load sequencer
  // ****************************************************************
  // the array word is taken in the first cycle after release, never
  // under reset itself, so fuse_word_in reaches no reset branch
  always @* begin
    next_state = state;
    next_fuse = general_fuse_low_word;
    case (state)
      ST_LOAD: begin
        next_fuse = fuse_word_in;
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (chip_erase_req) begin
          next_state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        next_fuse = `FWBD_ERASED_VALUE;
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_LOAD;
      general_fuse_low_word <= `FWBD_SHIP_VALUE;
      loaded <= 1'b0;
      erased <= 1'b0;
    end else begin
      state <= next_state;
      general_fuse_low_word <= next_fuse;
      if (state == ST_LOAD) begin
        loaded <= 1'b1;
      end
      if (state == ST_ERASE) begin
        erased <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // detector control register
  // ****************************************************************
  // a brown-out reset leaves the software setting in place; any other
  // reset returns it to the shipped fields and reloads it from fuses
  always @(posedge ref_clk) begin
    if (reset) begin
      if (bod_reset_cause) begin
        kept_on_bod <= 1'b1;
      end else begin
        kept_on_bod <= 1'b0;
        bodctl <= bod_fields(`FWBD_SHIP_VALUE);
      end
    end else begin
      if (state == ST_LOAD && !kept_on_bod) begin
        bodctl <= bod_fields(fuse_word_in);
      end else if (state == ST_ERASE) begin
        bodctl <= bod_fields(`FWBD_ERASED_VALUE);
      end else if (wr_stb && wr_ofs == `FWBD_OFS_BODCTL) begin
        bodctl <= bod_fields(wr_data);
      end
    end
  end

  // ****************************************************************
  // detector outputs
  // ****************************************************************
  assign bod_mode = bod_mode_of(bodctl[`FWBD_EN_HI:`FWBD_EN_LO]);

  always @(posedge ref_clk) begin
    if (reset) begin
      bod_enable <= 1'b0;
      bod_reset_enable <= 1'b0;
      bod_hysteresis <= 1'b1;
      bod_level <= `FWBD_LVL_MIN;
      bod_level_below_por <= 1'b1;
    end else begin
      bod_enable <= bod_mode[1];
      bod_reset_enable <= bod_mode[0];
      bod_hysteresis <= bodctl[`FWBD_HYST];
      bod_level <= bodctl[`FWBD_LVL_HI:`FWBD_LVL_LO];
      // lowest level is below power-on reset: never fires there
      bod_level_below_por <=
        (bodctl[`FWBD_LVL_HI:`FWBD_LVL_LO] == `FWBD_LVL_MIN);
    end
  end

  // ****************************************************************
  // flash protection outputs
  // ****************************************************************
  // a lock fuse at zero locks its region
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_lock
      assign lock_active[gi] = ~general_fuse_low_word[`FWBD_LOCK_LO + gi];
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (reset) begin
      flash_region_lock <= 16'h0000;
      flash_user_page_protect <= 1'b1;
      flash_readout_protect_pair <= 2'h3;
      flash_boot_area_protect <= `FWBD_BOOT_OFF;
      flash_boot_protect_off <= 1'b1;
      flash_fetch_unlocked <= 1'b1;
      flash_fuse_bits <= 7'h7F;
    end else begin
      flash_region_lock <= lock_active;
      flash_user_page_protect <= general_fuse_low_word[`FWBD_USER_PAGE];
      flash_readout_protect_pair <=
        general_fuse_low_word[`FWBD_SEC_HI:`FWBD_SEC_LO];
      flash_boot_area_protect <=
        general_fuse_low_word[`FWBD_BOOT_HI:`FWBD_BOOT_LO];
      flash_boot_protect_off <=
        (general_fuse_low_word[`FWBD_BOOT_HI:`FWBD_BOOT_LO] == `FWBD_BOOT_OFF);
      flash_fetch_unlocked <= general_fuse_low_word[`FWBD_FETCH_LOCK];
      flash_fuse_bits <=
        general_fuse_low_word[`FWBD_FLASH_HI:`FWBD_FLASH_LO];
    end
  end

endmodule // fwbd_decode

// ### core/fwbd_defs.vh
/*
 * constants for the fuse word decoder: register offsets, fuse word
 * field positions, fixed values and codes.
 * assumes it is included by bare name from the core/ design files.
 */
`ifndef FWBD_DEFS_VH
`define FWBD_DEFS_VH

// ****************************************************************
// register offsets (byte address, low eight bits of haddr)
// ****************************************************************
`define FWBD_OFS_FUSE 8'h00
`define FWBD_OFS_BODCTL 8'h04
`define FWBD_OFS_STATUS 8'h08

// ****************************************************************
// fuse word field positions
// ****************************************************************
`define FWBD_EN_HI 31
`define FWBD_EN_LO 30
`define FWBD_HYST 29
`define FWBD_LVL_HI 28
`define FWBD_LVL_LO 23
`define FWBD_USER_PAGE 22
`define FWBD_SEC_HI 21
`define FWBD_SEC_LO 20
`define FWBD_BOOT_HI 19
`define FWBD_BOOT_LO 17
`define FWBD_FETCH_LOCK 16
`define FWBD_FLASH_HI 22
`define FWBD_FLASH_LO 16
`define FWBD_LOCK_HI 15
`define FWBD_LOCK_LO 0

// ****************************************************************
// status register bit positions
// ****************************************************************
`define FWBD_ST_LOADED 0
`define FWBD_ST_ERASED 1
`define FWBD_ST_KEPT 2

// ****************************************************************
// values and codes
// ****************************************************************
`define FWBD_SHIP_VALUE 32'hE07F_FFFF
`define FWBD_ERASED_VALUE 32'h0FFF_FFFF
`define FWBD_BODCTL_MASK 32'hFF80_0000
`define FWBD_EN_OFF_LO 2'h0
`define FWBD_EN_RST 2'h1
`define FWBD_EN_NORST 2'h2
`define FWBD_EN_OFF_HI 2'h3
`define FWBD_LVL_MIN 6'h00
`define FWBD_BOOT_OFF 3'h7
`define FWBD_HTRANS_NONSEQ 2'h2
`define FWBD_HSIZE_WORD 3'h2

`endif

// ### core/fwbd_ahb_slave.v
/*
 * ahb-lite slave front end for the fuse word decoder: captures the
 * address phase, issues a one-cycle write strobe in the cycle after the data phase and
 * registers read data at the address phase.
 * assumes a single master, whole-word transfers, inputs synchronous.
 */
`include "fwbd_defs.vh"

module fwbd_ahb_slave (
  input wire ref_clk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] fuse_image,
  input wire [31:0] bodctl_image,
  input wire [31:0] status_image,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg wr_stb,
  output reg [7:0] wr_ofs,
  output wire [31:0] wr_data
);

  wire take;
  reg wr_pend;
  reg [31:0] wr_word;

  // only nonsequential transfers are acted on; writes must also be word-sized
  assign take = hsel && hready && (htrans == `FWBD_HTRANS_NONSEQ);
  // write data is captured at the end of its own data phase, since the
  // master may already show the next transfer's data one cycle later
  assign wr_data = wr_word;

  // ****************************************************************
  // read mux, latched at the address phase
  // ****************************************************************
  function [31:0] read_mux;
    input [7:0] ofs;
    begin
      if (ofs == `FWBD_OFS_FUSE) begin
        read_mux = fuse_image;
      end else if (ofs == `FWBD_OFS_BODCTL) begin
        read_mux = bodctl_image;
      end else if (ofs == `FWBD_OFS_STATUS) begin
        read_mux = status_image;
      end else begin
        read_mux = 32'h0000_0000;
      end
    end
  endfunction

  always @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_stb <= 1'b0;
      wr_ofs <= 8'h00;
      wr_word <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_stb <= 1'b0;
      wr_pend <= 1'b0;
      if (take && !hwrite) begin
        hrdata <= read_mux(haddr[7:0]);
      end
      if (take && hwrite && hsize == `FWBD_HSIZE_WORD) begin
        wr_ofs <= haddr[7:0];
        wr_pend <= 1'b1;
      end
      // data phase follows the captured address phase
      if (wr_pend) begin
        wr_stb <= 1'b1;
        wr_word <= hwdata;
      end
    end
  end

endmodule // fwbd_ahb_slave

// ### tb/fwbd_props.sv
/* assertions on fwbd_decode outputs.
   assumes the bind below, sync active-high reset, core/ on include path. */
`include "fwbd_defs.vh"
module fwbd_props (
  input wire ref_clk,
  input wire reset,
  input wire chip_erase_req,
  input wire hreadyout,
  input wire hresp,
  input wire bod_enable,
  input wire bod_reset_enable,
  input wire bod_hysteresis,
  input wire [5:0] bod_level,
  input wire bod_level_below_por,
  input wire [15:0] flash_region_lock,
  input wire flash_user_page_protect,
  input wire [1:0] flash_readout_protect_pair,
  input wire [2:0] flash_boot_area_protect,
  input wire flash_boot_protect_off,
  input wire flash_fetch_unlocked,
  input wire [6:0] flash_fuse_bits
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // properties
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_run3;
    !$past(reset) && !$past(reset, 2) && !$past(reset, 3);
  endsequence
  sequence s_erased;
    flash_fuse_bits == 7'h7F && flash_region_lock == 16'h0000 && !bod_enable
      && !bod_hysteresis && bod_level == 6'h1F;
  endsequence
  property p_rst_en; bod_reset_enable |-> bod_enable; endproperty
  property p_por; bod_level_below_por == (bod_level == `FWBD_LVL_MIN); endproperty
  property p_boot; flash_boot_protect_off == (flash_boot_area_protect == 3'h7); endproperty
  property p_raw;
    flash_fuse_bits == {flash_user_page_protect, flash_readout_protect_pair,
      flash_boot_area_protect, flash_fetch_unlocked};
  endproperty
  // kept-bodctl resets still force fixed detector outputs; only the flash side is checked here
  property p_ship;
    disable iff (1'b0) reset |=> flash_fuse_bits == 7'h7F && flash_region_lock == 16'h0000;
  endproperty
  property p_erase; s_run3 ##0 chip_erase_req |-> ##3 s_erased; endproperty
  property p_stable;
    s_run3 ##0 !$past(chip_erase_req) && !$past(chip_erase_req, 2)
      && !$past(chip_erase_req, 3) |-> $stable(flash_fuse_bits) && $stable(flash_region_lock);
  endproperty
  property p_bus; hreadyout && !hresp; endproperty
  a_rst_en: assert property (p_rst_en) else $error("reset on while detector off");
  a_por: assert property (p_por) else $error("below-por flag wrong");
  a_boot: assert property (p_boot) else $error("boot protect off flag wrong");
  a_raw: assert property (p_raw) else $error("flash fuse bits differ");
  a_ship: assert property (p_ship) else $error("not shipped decode in reset");
  a_erase: assert property (p_erase) else $error("erase decode wrong");
  a_stable: assert property (p_stable) else $error("flash outputs moved");
  a_bus: assert property (p_bus) else $error("bus not ready or error");
endmodule // fwbd_props
bind fwbd_decode fwbd_props u_props (.*);

// ### tb/fwbd_bod_model.sv
/* far-side detector: fires a reset when supply sits below the level.
   assumes decoded detector outputs of fwbd_decode. */
module fwbd_bod_model (
  input wire bod_enable,
  input wire bod_reset_enable,
  input wire bod_level_below_por,
  input wire [5:0] bod_level,
  input wire [5:0] supply_code,
  output wire bod_fire
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // trigger
  // ****
  assign bod_fire = bod_enable && bod_reset_enable && !bod_level_below_por
    && (supply_code < bod_level);
endmodule // fwbd_bod_model

// ### tb/fwbd_decode_bench.sv
/* self-checking bench for fwbd_decode with the detector model.
   assumes core/ on include path; hready is the slave's hreadyout. */
`include "fwbd_defs.vh"
module fwbd_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, reset, bod_reset_cause, chip_erase_req, hsel, hwrite, hreadyout, hresp;
  logic [31:0] fuse_word_in, haddr, hwdata, hrdata, r;
  logic [1:0] htrans, flash_readout_protect_pair;
  logic [2:0] hsize, flash_boot_area_protect;
  logic bod_enable, bod_reset_enable, bod_hysteresis, bod_level_below_por, bod_fire;
  logic flash_user_page_protect, flash_boot_protect_off, flash_fetch_unlocked;
  logic [5:0] bod_level;
  logic [5:0] supply_code = 6'h00;
  logic [15:0] flash_region_lock;
  logic [6:0] flash_fuse_bits;
  wire hready;
  int failures, n_checks;
  typedef struct packed {logic [31:0] w; logic [1:0] e; logic f;} fwbd_row_t;
  fwbd_row_t rows [4] = '{'{32'hE07F_FFFF, 2'b00, 1'b0}, '{32'h5F8E_1234, 2'b11, 1'b1},
    '{32'h8081_00FF, 2'b10, 1'b0}, '{32'h1000_0000, 2'b00, 1'b0}};
  assign hready = hreadyout;
  fwbd_decode dut (.*);
  fwbd_bod_model u_bod (.*);
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rst(input logic cause);
    reset <= 1'b1;
    bod_reset_cause <= cause;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    bod_reset_cause <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= `FWBD_HTRANS_NONSEQ;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****
  // stimulus
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    conclude();
  end
  initial begin
    {reset, bod_reset_cause, chip_erase_req, hsel, hwrite} = 5'b10010;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, `FWBD_HSIZE_WORD};
    fuse_word_in = `FWBD_SHIP_VALUE;
    foreach (rows[i]) begin
      fuse_word_in <= rows[i].w;
      rst(1'b0);
      chk({bod_enable, bod_reset_enable}, rows[i].e);
      chk(bod_hysteresis, rows[i].w[29]);
      chk(bod_level, rows[i].w[28:23]);
      chk(flash_region_lock, 16'(~rows[i].w[15:0]));
      chk(flash_fuse_bits, rows[i].w[22:16]);
      chk(flash_boot_protect_off, &rows[i].w[19:17]);
      chk(flash_fetch_unlocked, rows[i].w[16]);
      chk(bod_fire, rows[i].f);
      chk(bod_level_below_por, rows[i].w[28:23] == 6'h00);
      bus(1'b0, `FWBD_OFS_FUSE, 32'h0);
      chk(r, rows[i].w);
    end
    $display("test decode rows done");
    bus(1'b1, `FWBD_OFS_BODCTL, 32'h5A00_1234);
    repeat (3) @(posedge ref_clk);
    chk({bod_enable, bod_reset_enable, bod_level}, {2'b11, 6'h34});
    bus(1'b0, `FWBD_OFS_BODCTL, 32'h0);
    chk(r, 32'h5A00_0000);
    bus(1'b1, `FWBD_OFS_FUSE, 32'h0);
    bus(1'b0, `FWBD_OFS_FUSE, 32'h0);
    chk(r, rows[3].w);
    bus(1'b0, 8'h0C, 32'h0);
    chk(r, 32'h0);
    $display("test register access done");
    rst(1'b1);
    chk({bod_enable, bod_reset_enable}, 2'b11);
    bus(1'b0, `FWBD_OFS_STATUS, 32'h0);
    chk(r[`FWBD_ST_KEPT], 1'b1);
    rst(1'b0);
    chk(bod_enable, 1'b0);
    $display("test brown-out reset done");
    chip_erase_req <= 1'b1;
    @(posedge ref_clk);
    chip_erase_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(bod_level, 6'h1F);
    bus(1'b0, `FWBD_OFS_FUSE, 32'h0);
    chk(r, `FWBD_ERASED_VALUE);
    $display("test chip erase done");
    conclude();
  end
endmodule // fwbd_decode_bench
